//--- hw/emu_block_map.sv
// enable map: one bit per 2k block of the 128k window
`timescale 1ns/1ps
`default_nettype none
module emu_block_map
	import emu_rom_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	input  wire host_cmd_t           cmd,
	input  wire logic                segLow,
	output logic [MAP_BITS-1:0]      enableMap
);
	typedef struct packed {
		logic [MAP_BITS-1:0] map;
	} map_state_t;

	map_state_t state;
	map_state_t next_state;
	logic [4:0] firstBlk;
	logic [4:0] lastBlk;

	always_comb begin
		next_state = state;
		firstBlk = cmd.fromAddr[BLK_MSB:BLK_LSB];
		// single address covers its whole block
		lastBlk = cmd.isRange ? cmd.toAddr[BLK_MSB:BLK_LSB] : firstBlk;
		if (cmd.clearAllEnables) begin
			next_state.map = MAP_RESET;
		end else if (cmd.blockEnableRequest) begin
			if (!cmd.additive) begin
				next_state.map = MAP_RESET;
			end
			for (int i = 0; i < 32; i++) begin
				if (5'(i) >= firstBlk && 5'(i) <= lastBlk) begin
					next_state.map[{segLow, 5'(i)}] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state.map <= MAP_RESET;
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	assign enableMap = state.map;
endmodule : emu_block_map
`default_nettype wire

//--- hw/emu_rom_decoder.sv
// emulation rom address decoder and responder
`timescale 1ns/1ps
`default_nettype none
module emu_rom_decoder
	import emu_rom_pkg::*;
(
	input  wire logic                clk_sys,
	input  wire logic                rst_n,
	input  wire logic                clkEn,
	input  wire host_cmd_t           hostCmd,
	input  wire logic                hostRamWrite,
	input  wire logic [RAM_AW-1:0]   hostRamAddr,
	input  wire logic [DATA_W-1:0]   hostRamData,
	input  wire target_bus_t         targetBus,
	output logic [DATA_W-1:0]        targetData,
	output logic                     targetDataOe,
	output logic [SEG_W-1:0]         segmentValue,
	output logic [MAP_BITS-1:0]      showEnableState
);
	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addrMeta;
		logic [ADDR_W-1:0] addrSync;
		logic [1:0]        rdMeta;
		logic [1:0]        rdSync;
		logic [SEG_W-1:0]  seg;
		logic [DATA_W-1:0] dataOut;
		logic              oe;
	} dec_state_t;

	dec_state_t state;
	dec_state_t next_state;
	logic [MAP_BITS-1:0] enableMap;
	logic [DATA_W-1:0]   ram [0:(1<<RAM_AW)-1];
	logic                segHit;
	logic                blkHit;
	logic                rdActive;

	// segment match ignoring A16, which the map holds
	function automatic logic upperMatch(input logic [SEG_W-1:0] a, input logic [SEG_W-1:0] b);
		upperMatch = (a[SEG_W-1:1] == b[SEG_W-1:1]);
	endfunction : upperMatch

	emu_block_map u_map (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.clkEn     (clkEn),
		.cmd       (hostCmd),
		.segLow    (state.seg[0]),
		.enableMap (enableMap)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	always_comb begin
		next_state = state;
		next_state.addrMeta = targetBus.addr;
		next_state.addrSync = state.addrMeta;
		next_state.rdMeta = {targetBus.writeStrobe, targetBus.readStrobe};
		next_state.rdSync = state.rdMeta;
		if (hostCmd.setSegmentValue) begin
			next_state.seg = hostCmd.segmentValue;
		end
		rdActive = state.rdSync[0] && !state.rdSync[1];
		// an even segment and the odd one above it share the top three bits only
		segHit = upperMatch(state.addrSync[ADDR_W-1:SEG_LSB], state.seg);
		blkHit = segHit && enableMap[state.addrSync[SEG_LSB:BLK_LSB]];
		next_state.oe = rdActive && blkHit;
		next_state.dataOut = ram[state.addrSync[RAM_AW-1:0]];
	end

	// ram written only from host; target write strobe never reaches it
	always_ff @(posedge clk_sys) begin
		if (clkEn && hostRamWrite) begin
			ram[hostRamAddr] <= hostRamData;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state.addrMeta <= '0;
			state.addrSync <= '0;
			state.rdMeta <= 2'h0;
			state.rdSync <= 2'h0;
			state.seg <= SEG_RESET;
			state.dataOut <= 8'h00;
			state.oe <= 1'b0;
		end else if (clkEn) begin
			state <= next_state;
		end
	end

	assign targetData = state.dataOut;
	assign targetDataOe = state.oe;
	assign segmentValue = state.seg;
	assign showEnableState = enableMap;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_segMiss;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !upperMatch(state.addrSync[19:16], state.seg)) |=> !targetDataOe;
	endproperty
	a_segMiss: assert property (p_segMiss) else $error("drove on segment miss");

	property p_blkMiss;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !enableMap[state.addrSync[16:11]]) |=> !targetDataOe;
	endproperty
	a_blkMiss: assert property (p_blkMiss) else $error("drove on disabled block");

	property p_hit;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && rdActive && blkHit) |=> targetDataOe;
	endproperty
	a_hit: assert property (p_hit) else $error("missed enabled read");

	property p_noWrite;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && state.rdSync[1]) |=> !targetDataOe;
	endproperty
	a_noWrite: assert property (p_noWrite) else $error("answered a target write");

	property p_seg;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.setSegmentValue) |=> segmentValue == $past(hostCmd.segmentValue);
	endproperty
	a_seg: assert property (p_seg) else $error("segment not stored");

	property p_replace;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && !hostCmd.additive && !hostCmd.clearAllEnables
			&& hostCmd.fromAddr[15:11] != 5'h1F && !hostCmd.isRange) |=> !showEnableState[{segmentValue[0], 5'h1F}];
	endproperty
	a_replace: assert property (p_replace) else $error("old enable kept");

	property p_single;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && !hostCmd.clearAllEnables && !hostCmd.isRange)
			|=> showEnableState[{$past(segmentValue[0]), $past(hostCmd.fromAddr[15:11])}];
	endproperty
	a_single: assert property (p_single) else $error("single block not enabled");

	property p_fold;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && rdActive && blkHit) |=> targetData == $past(ram[state.addrSync[14:0]]);
	endproperty
	a_fold: assert property (p_fold) else $error("wrong ram index");

	// top three bits must match the segment whatever half the map picks
	property p_topBits;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && state.addrSync[19:17] != segmentValue[3:1]) |=> !targetDataOe;
	endproperty
	a_topBits: assert property (p_topBits) else $error("drove outside the top three bits");

	property p_noRead;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && !state.rdSync[0]) |=> !targetDataOe;
	endproperty
	a_noRead: assert property (p_noRead) else $error("drove without a read");

	// ****************************************************************
	// checks on host commands, reset and freeze
	// ****************************************************************
	// no disable here: the reset branch itself is under test
	property p_resetVal;
		@(posedge clk_sys)
		!rst_n |=> segmentValue == SEG_RESET && showEnableState == MAP_RESET && !targetDataOe;
	endproperty
	a_resetVal: assert property (p_resetVal) else $error("reset values wrong");

	property p_clear;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.clearAllEnables) |=> showEnableState == MAP_RESET;
	endproperty
	a_clear: assert property (p_clear) else $error("clear left enables");

	property p_additive;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && hostCmd.additive && !hostCmd.clearAllEnables)
			|=> (showEnableState | $past(showEnableState)) == showEnableState;
	endproperty
	a_additive: assert property (p_additive) else $error("additive enable lost old blocks");

	property p_range;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && hostCmd.isRange && !hostCmd.clearAllEnables
			&& hostCmd.fromAddr[15:11] <= hostCmd.toAddr[15:11])
			|=> showEnableState[{$past(segmentValue[0]), $past(hostCmd.toAddr[15:11])}];
	endproperty
	a_range: assert property (p_range) else $error("range end block not enabled");

	// a replacing request leaves the other map half empty
	property p_otherHalf;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && !hostCmd.additive && !hostCmd.clearAllEnables)
			|=> ($past(segmentValue[0]) ? showEnableState[31:0] : showEnableState[63:32]) == 32'h0;
	endproperty
	a_otherHalf: assert property (p_otherHalf) else $error("enable leaked into other segment");

	property p_oneBlock;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && hostCmd.blockEnableRequest && !hostCmd.additive && !hostCmd.isRange
			&& !hostCmd.clearAllEnables) |=> $countones(showEnableState) == 1;
	endproperty
	a_oneBlock: assert property (p_oneBlock) else $error("single address enabled more than a block");

	// clock enable low must hold every visible state
	property p_freeze;
		@(posedge clk_sys) disable iff (!rst_n)
		!clkEn |=> $stable(segmentValue) && $stable(showEnableState) && $stable(targetDataOe);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : emu_rom_decoder
`default_nettype wire

//--- inc/emu_rom_pkg.sv
// shared constants and carrier types for the emulation rom decoder
`default_nettype none
package emu_rom_pkg;
	localparam int ADDR_W     = 20;
	localparam int SEG_W      = 4;
	localparam int DATA_W     = 8;
	localparam int RAM_AW     = 15;
	localparam int MAP_BITS   = 64;
	localparam int BLK_MSB    = 15;
	localparam int BLK_LSB    = 11;
	localparam int SEG_LSB    = 16;
	localparam logic [SEG_W-1:0] SEG_RESET = 4'hF;
	localparam logic [MAP_BITS-1:0] MAP_RESET = 64'h0000000000000000;

	// host-side command carrier
	typedef struct packed {
		logic        setSegmentValue;
		logic [3:0]  segmentValue;
		logic        blockEnableRequest;
		logic        additive;
		logic        isRange;
		logic [15:0] fromAddr;
		logic [15:0] toAddr;
		logic        clearAllEnables;
	} host_cmd_t;

	// target bus carrier
	typedef struct packed {
		logic [19:0] addr;
		logic        readStrobe;
		logic        writeStrobe;
	} target_bus_t;
endpackage : emu_rom_pkg
`default_nettype wire

//--- testbench/target_cpu_model.sv
// behavioural target processor fetching from the emulated rom socket
`timescale 1ns/1ps
`default_nettype none
module target_cpu_model
	import emu_rom_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic [DATA_W-1:0] targetData,
	input  wire logic              targetDataOe,
	output var  target_bus_t       targetBus
);
	initial targetBus = '{20'h00000, 1'b0, 1'b0};

	// one bus cycle; strobe held long enough for the synced answer
	task fetch(input logic [19:0] a, input logic wr, output logic hit, output logic [7:0] d);
		hit = 1'b0;
		@(posedge clk_sys);
		targetBus <= '{a, ~wr, wr};
		repeat (6) begin
			@(posedge clk_sys);
			#1;
			if (targetDataOe === 1'b1 && !hit) begin
				hit = 1'b1;
				d = targetData;
			end
		end
		// released address shows its inverse and both strobes drop, so a stale match cannot hide
		@(posedge clk_sys);
		targetBus <= '{~a, 1'b0, 1'b0};
		repeat (3) @(posedge clk_sys);
	endtask : fetch
endmodule : target_cpu_model
`default_nettype wire

//--- testbench/tb.sv
// self-checking testbench for the emulation rom decoder
`timescale 1ns/1ps
`default_nettype none
module tb
	import emu_rom_pkg::*;
;
	logic                clk_sys = 1'b0;
	logic                rst_n = 1'b0;
	logic                clkEn = 1'b1;
	host_cmd_t           hostCmd = '0;
	logic                hostRamWrite = 1'b0;
	logic [RAM_AW-1:0]   hostRamAddr = '0;
	logic [DATA_W-1:0]   hostRamData = '0;
	target_bus_t         targetBus;
	logic [DATA_W-1:0]   targetData;
	logic                targetDataOe;
	logic [SEG_W-1:0]    segmentValue;
	logic [MAP_BITS-1:0] showEnableState;
	logic [7:0]          rm [32768];
	logic [63:0]         eMap = '0;
	logic [3:0]          eSeg = 4'hF;
	logic [7:0]          d0, d1;
	logic [19:0]         ra;
	int                  failures = 0;
	int                  n_tests = 0;

	always #25 clk_sys = ~clk_sys;

	emu_rom_decoder dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .hostCmd(hostCmd),
		.hostRamWrite(hostRamWrite), .hostRamAddr(hostRamAddr), .hostRamData(hostRamData),
		.targetBus(targetBus), .targetData(targetData), .targetDataOe(targetDataOe),
		.segmentValue(segmentValue), .showEnableState(showEnableState));
	target_cpu_model cpu (.clk_sys(clk_sys), .targetData(targetData), .targetDataOe(targetDataOe),
		.targetBus(targetBus));

	// ****************************************
	// checking and closing
	// ****************************************
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task summarize;
		$display("comparisons=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	// ****************************************
	// host commands and target fetches
	// ****************************************
	task cmd(input host_cmd_t c);
		@(posedge clk_sys);
		hostCmd <= c;
		@(posedge clk_sys);
		hostCmd <= '0;
		@(posedge clk_sys);
	endtask : cmd

	task seg(input logic [3:0] v);
		eSeg = v;
		cmd('{1'b1, v, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0});
		chk(segmentValue, v);
	endtask : seg

	task enb(input logic add, input logic rng, input logic [15:0] f, input logic [15:0] t);
		int e;
		e = rng ? t[15:11] : f[15:11];
		if (!add) eMap = '0;
		for (int i = f[15:11]; i <= e; i++) eMap[{eSeg[0], 5'(i)}] = 1'b1;
		cmd('{1'b0, 4'h0, 1'b1, add, rng, f, t, 1'b0});
		chk(showEnableState, eMap);
	endtask : enb

	task fet(input logic [19:0] a, input logic wr, output logic [7:0] d);
		logic h;
		logic e;
		cpu.fetch(a, wr, h, d);
		e = !wr && eSeg[3:1] == a[19:17] && eMap[{a[16], a[15:11]}];
		chk(h, e);
		if (e) chk(d, rm[a[14:0]]);
	endtask : fet

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		#5_000_000;
		failures++;
		summarize();
	end

	initial begin
		void'($urandom(32'hE718));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk(segmentValue, 4'hF);
		chk(showEnableState, 64'h0);
		for (int i = 0; i < 32768; i++) begin
			@(posedge clk_sys);
			rm[i] = 8'($urandom);
			hostRamWrite <= 1'b1;
			hostRamAddr <= 15'(i);
			hostRamData <= rm[i];
		end
		@(posedge clk_sys);
		hostRamWrite <= 1'b0;
		seg(4'h4);
		enb(1'b0, 1'b1, 16'h0000, 16'h17FF);
		seg(4'h5);
		enb(1'b1, 1'b1, 16'h1000, 16'h17FF);
		fet(20'h40800, 1'b0, d0);
		fet(20'h51000, 1'b0, d0);
		fet(20'h60000, 1'b0, d0);
		fet(20'h51000, 1'b1, d0);
		seg(4'h4);
		enb(1'b1, 1'b1, 16'h8000, 16'h87FF);
		fet(20'h40000, 1'b0, d0);
		fet(20'h48000, 1'b0, d1);
		chk(d1, d0);
		enb(1'b0, 1'b0, 16'h1000, 16'h0000);
		fet(20'h41000, 1'b0, d0);
		fet(20'h40000, 1'b0, d0);
		eMap = '0;
		cmd('{1'b0, 4'h0, 1'b1, 1'b0, 1'b1, 16'h0000, 16'hFFFF, 1'b1});
		chk(showEnableState, eMap);
		enb(1'b0, 1'b1, 16'h0000, 16'hFFFF);
		// mid-run reset with the lower map half full: both map and segment must return to reset
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		eSeg = 4'hF;
		eMap = '0;
		chk(segmentValue, eSeg);
		chk(showEnableState, eMap);
		// frozen clock enable: a whole command must leave no trace
		clkEn <= 1'b0;
		cmd('{1'b1, 4'h7, 1'b1, 1'b0, 1'b1, 16'h0000, 16'hFFFF, 1'b0});
		clkEn <= 1'b1;
		chk(segmentValue, eSeg);
		chk(showEnableState, eMap);
		seg(4'h4);
		enb(1'b0, 1'b1, 16'h0000, 16'hFFFF);
		seg(4'h5);
		enb(1'b1, 1'b1, 16'h0800, 16'hF7FF);
		repeat (60) begin
			ra = 20'($urandom);
			if (ra[19]) ra[19:17] = 3'b010;
			fet(ra, 1'($urandom_range(0, 7) == 0), d0);
		end
		summarize();
	end
endmodule : tb
`default_nettype wire
